//--- cprs_shaper.sv
`timescale 1ns/1ps
module cprs_shaper (
    input  wire logic                                             clk,
    input  wire logic                                             resetn,
    input  wire logic                                             clk_en,
    input  wire logic                                             bus_16bit,
    input  wire logic                                             correction_en,
    input  wire cprs_pkg::cprs_poll_t                             poll_mode,
    input  wire logic [cprs_pkg::NUM_PORTS-1:0][cprs_pkg::INTV_W-1:0] shaping_interval,
    input  wire logic [cprs_pkg::NUM_PORTS-1:0]                   cell_pending,
    output logic                                                  cycle_start,
    output logic                                                  grant_valid,
    output logic [cprs_pkg::PORT_W-1:0]                           grant_port
);
    import cprs_pkg::*;

    // ************************************************************
    // reset release
    // ************************************************************
    logic                  rst_meta;
    logic                  rst_n;
    logic [CYC_W-1:0]      cyc_cnt;
    logic [INTV_W-1:0]     interval_countdown [NUM_PORTS];
    logic [SLIP_W-1:0]     slip [NUM_PORTS];
    logic [PORT_W-1:0]     last_win;
    logic [NUM_PORTS-1:0]  req;
    logic [INTV_W-1:0]     next_countdown [NUM_PORTS];
    logic [SLIP_W-1:0]     next_slip [NUM_PORTS];
    wire  [CYC_W-1:0]      cyc_last;
    wire                   tick;
    wire                   any_req;
    wire  [PORT_W-1:0]     win;
    logic [SLIP_W-1:0]     slip_max;

    // two flops release the asynchronous reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ************************************************************
    // basic cycle timer
    // ************************************************************
    // last count of the cycle depends on bus width
    assign cyc_last = bus_16bit ? CYC_LEN_16BIT - 6'h01 : CYC_LEN_8BIT - 6'h01;
    assign tick     = clk_en && (cyc_cnt == cyc_last);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cyc_cnt <= CYC_RST;
        end else if (clk_en) begin
            cyc_cnt <= (cyc_cnt >= cyc_last) ? CYC_RST : cyc_cnt + 6'h01;
        end
    end

    // ************************************************************
    // slip maximum by polling mode
    // ************************************************************
    // unknown mode codes fall back to the widest range
    always_comb begin
        unique case (poll_mode)
            CPRS_POLL_12: slip_max = SLIP_MAX_12;
            CPRS_POLL_15: slip_max = SLIP_MAX_15;
            CPRS_POLL_MUX,
            CPRS_POLL_2G,
            CPRS_POLL_1G: slip_max = SLIP_MAX_29;
            default:      slip_max = SLIP_MAX_29;
        endcase
    end

    // ************************************************************
    // winner selection
    // ************************************************************
    // rotating search starting after the last winner
    function automatic logic [PORT_W-1:0] pick(input logic [NUM_PORTS-1:0] r, input logic [PORT_W-1:0] last);
        logic [PORT_W-1:0] idx;
        logic [PORT_W-1:0] res;
        logic              found;
        idx   = last;
        res   = last;
        found = 1'b0;
        for (int k = 0; k < NUM_PORTS; k++) begin
            idx = (idx == PORT_W'(NUM_PORTS - 1)) ? '0 : idx + 5'h01;
            if (!found && r[idx]) begin
                res   = idx;
                found = 1'b1;
            end
        end
        return res;
    endfunction

    assign any_req = |req;
    assign win     = pick(req, last_win);

    // ************************************************************
    // per-port countdown and slip
    // ************************************************************
    for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
        wire                won;
        wire [INTV_W-1:0]   corrected;
        wire [INTV_W-1:0]   reload;
        // only a zero countdown with a cell can contend
        assign req[i]     = cell_pending[i] && (interval_countdown[i] == 8'h00);
        assign won        = tick && any_req && (win == PORT_W'(i));
        assign corrected  = (shaping_interval[i] > INTV_W'(slip[i])) ?
                            shaping_interval[i] - INTV_W'(slip[i]) : 8'h00;
        assign reload     = correction_en ? corrected : shaping_interval[i];
        // winners reload, ports at zero hold there, others count down
        assign next_countdown[i] = won ? reload :
                                   (interval_countdown[i] != 8'h00) ?
                                   interval_countdown[i] - 8'h01 : 8'h00;
        assign next_slip[i] = won ? SLIP_RST :
                              !req[i] ? slip[i] :
                              (slip[i] >= slip_max) ? slip_max : slip[i] + 5'h01;

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                interval_countdown[i] <= COUNTDOWN_RST;
                slip[i]               <= SLIP_RST;
            end else if (tick) begin
                interval_countdown[i] <= next_countdown[i];
                slip[i]               <= next_slip[i];
            end
        end
    end

    // ************************************************************
    // grant outputs
    // ************************************************************
    // at most one grant per basic cycle, a pulse of one enabled clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cycle_start <= 1'b0;
            grant_valid <= 1'b0;
            grant_port  <= '0;
            last_win    <= PORT_RST;
        end else if (clk_en) begin
            cycle_start <= tick;
            grant_valid <= tick && any_req;
            if (tick && any_req) begin
                grant_port <= win;
                last_win   <= win;
            end
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    sequence s_contend0;
        tick && req[0] && (win != 5'h00);
    endsequence

    a_cycle_spacing: assert property (@(posedge clk) disable iff (!rst_n)
        tick |=> !tick [*8]) else $error("basic cycles closer than expected");
    a_grant_winner: assert property (@(posedge clk) disable iff (!rst_n)
        tick && any_req |=> grant_valid && grant_port == $past(win)) else $error("grant not given to winner");
    a_no_grant_idle: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && !(tick && any_req) |=> !grant_valid) else $error("grant without eligible port");
    a_plain_reload: assert property (@(posedge clk) disable iff (!rst_n)
        tick && any_req && !correction_en |=>
        interval_countdown[$past(win)] == $past(shaping_interval[win])) else $error("countdown not reloaded");
    a_slip_cleared: assert property (@(posedge clk) disable iff (!rst_n)
        tick && any_req |=> slip[$past(win)] == 5'h00) else $error("slip not cleared on grant");
    a_countdown_dec: assert property (@(posedge clk) disable iff (!rst_n)
        tick && interval_countdown[0] != 8'h00 |=>
        interval_countdown[0] == $past(interval_countdown[0]) - 8'h01) else $error("countdown not decremented");
    a_loser_hold: assert property (@(posedge clk) disable iff (!rst_n)
        s_contend0 |=> interval_countdown[0] == 8'h00 &&
        (slip[0] == $past(slip[0]) + 5'h01 || slip[0] == $past(slip_max))) else $error("loser state wrong");
    a_slip_bound: assert property (@(posedge clk) disable iff (!rst_n)
        tick |=> slip[0] <= $past(slip_max) || slip[0] == $past(slip[0])) else $error("slip above maximum");
    a_corrected_load: assert property (@(posedge clk) disable iff (!rst_n)
        tick && any_req && correction_en && win == 5'h00 && shaping_interval[0] > 8'(slip[0]) |=>
        interval_countdown[0] == $past(shaping_interval[0]) - 8'($past(slip[0]))) else $error("corrected load wrong");

    // ************************************************************
    // grant and slip checks
    // ************************************************************
    // a grant opportunity taken at the tick
    sequence s_granting;
        tick && any_req;
    endsequence

    // port 0 loses a conflict under the 12-port limit
    sequence s_lose0_12;
        tick && req[0] && (win != 5'h00) && (poll_mode == CPRS_POLL_12);
    endsequence

    // port 0 loses a conflict under the 15-port limit
    sequence s_lose0_15;
        tick && req[0] && (win != 5'h00) && (poll_mode == CPRS_POLL_15);
    endsequence

    // port 0 at zero with no cell waiting
    sequence s_idle0;
        tick && !cell_pending[0] && (interval_countdown[0] == 8'h00);
    endsequence

    // the chosen port must itself be eligible
    a_win_eligible: assert property (@(posedge clk) disable iff (!rst_n)
        s_granting |-> req[win]) else $error("winner was not eligible");

    // a grant only ever rides on a cycle pulse
    a_grant_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        grant_valid |-> cycle_start) else $error("grant outside a cycle pulse");

    // the winner index holds between grants
    a_port_hold: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && !(tick && any_req) |=> $stable(grant_port)) else $error("grant port moved without grant");

    // slip stays inside the 12-port range
    a_slip_max12: assert property (@(posedge clk) disable iff (!rst_n)
        s_lose0_12 |=> slip[0] <= SLIP_MAX_12) else $error("slip above 12-port limit");

    // slip stays inside the 15-port range
    a_slip_max15: assert property (@(posedge clk) disable iff (!rst_n)
        s_lose0_15 |=> slip[0] <= SLIP_MAX_15) else $error("slip above 15-port limit");

    // a zero port with nothing to send changes nothing
    a_idle_port: assert property (@(posedge clk) disable iff (!rst_n)
        s_idle0 |=> interval_countdown[0] == 8'h00 && $stable(slip[0])) else $error("idle port state changed");

    // a low enable freezes timer, cycle pulse and grant valid
    a_enable_freeze: assert property (@(posedge clk) disable iff (!rst_n)
        !clk_en |=> $stable(cyc_cnt) && $stable(cycle_start) && $stable(grant_valid))
        else $error("state moved while disabled");
endmodule

//--- cprs_pkg.sv
package cprs_pkg;
    // ************************************************************
    // sizes
    // ************************************************************
    localparam int NUM_PORTS  = 30;
    localparam int INTV_W     = 8;
    localparam int SLIP_W     = 5;
    localparam int PORT_W     = 5;
    localparam int CYC_W      = 6;

    // ************************************************************
    // basic cycle lengths in enabled clocks
    // ************************************************************
    localparam logic [CYC_W-1:0] CYC_LEN_8BIT  = 6'h2C; // 44 clocks
    localparam logic [CYC_W-1:0] CYC_LEN_16BIT = 6'h16; // 22 clocks

    // ************************************************************
    // slip maxima per polling mode
    // ************************************************************
    localparam logic [SLIP_W-1:0] SLIP_MAX_12 = 5'h0B;
    localparam logic [SLIP_W-1:0] SLIP_MAX_15 = 5'h0E;
    localparam logic [SLIP_W-1:0] SLIP_MAX_29 = 5'h1D;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [INTV_W-1:0] COUNTDOWN_RST = 8'h00;
    localparam logic [SLIP_W-1:0] SLIP_RST      = 5'h00;
    localparam logic [PORT_W-1:0] PORT_RST      = 5'h1D; // first pick is port 0
    localparam logic [CYC_W-1:0]  CYC_RST       = 6'h00;

    // polling modes, one-hot
    typedef enum logic [4:0] {
        CPRS_POLL_12  = 5'h01,
        CPRS_POLL_15  = 5'h02,
        CPRS_POLL_MUX = 5'h04,
        CPRS_POLL_2G  = 5'h08,
        CPRS_POLL_1G  = 5'h10
    } cprs_poll_t;
endpackage

//--- cprs_phy_model.sv
`timescale 1ns/1ps
module cprs_phy_model (
    input  wire logic                                  clk,
    input  wire logic                                  resetn,
    input  wire logic                                  load,
    input  wire logic [cprs_pkg::NUM_PORTS-1:0][7:0]   credit_init,
    input  wire logic                                  grant_valid,
    input  wire logic [cprs_pkg::PORT_W-1:0]           grant_port,
    output logic      [cprs_pkg::NUM_PORTS-1:0]        cell_pending
);
    import cprs_pkg::*;
    logic [NUM_PORTS-1:0][7:0] credit;
    // each grant pulls one queued cell from the winning port
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            credit <= '0;
        end else if (load) begin
            credit <= credit_init;
        end else if (grant_valid) begin
            credit[grant_port] <= credit[grant_port] - 8'h01;
        end
    end
    // a port offers a cell while one is still queued
    always_comb begin
        for (int i = 0; i < NUM_PORTS; i++) begin
            cell_pending[i] = (credit[i] != 8'h00);
        end
    end
endmodule

//--- tb.sv
`timescale 1ns/1ps
module tb;
    import cprs_pkg::*;
    logic                             clk, resetn, b16, corr, load, cyc, gv, seen_valid, en;
    cprs_poll_t                       poll;
    logic [NUM_PORTS-1:0][INTV_W-1:0] intv;
    logic [NUM_PORTS-1:0][7:0]        cr;
    logic [NUM_PORTS-1:0]             pend;
    logic [PORT_W-1:0]                gp, seen_port;
    int                               num_errors, n_compared, gap, n;

    cprs_shaper dut (.clk(clk), .resetn(resetn), .clk_en(en), .bus_16bit(b16), .correction_en(corr),
        .poll_mode(poll), .shaping_interval(intv), .cell_pending(pend), .cycle_start(cyc),
        .grant_valid(gv), .grant_port(gp));
    cprs_phy_model phy (.clk(clk), .resetn(resetn), .load(load), .credit_init(cr), .grant_valid(gv),
        .grant_port(gp), .cell_pending(pend));

    // free-running system clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic do_reset();
        resetn = 1'b0;
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        check("cycle_start", cyc, 0);
        check("grant_valid", gv, 0);
        @(negedge clk) load = 1'b1;
        @(negedge clk) load = 1'b0;
    endtask

    // wait for the next basic-cycle pulse and capture the grant
    task automatic next_cycle();
        gap = 0;
        do begin
            @(negedge clk);
            gap++;
        end while (cyc !== 1'b1 && gap < 60);
        if (gap >= 60) begin
            num_errors++;
            $display("Error cycle_start expected pulse seen none");
            end_sim();
        end
        seen_valid = gv;
        seen_port = gp;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic s_rate(input logic bus, input logic [7:0] intv_set, input int port);
        b16 = bus;
        corr = 1'b0;
        cr = '0;
        cr[port] = 8'hFF;
        intv = '0;
        intv[port] = intv_set;
        do_reset();
        next_cycle();
        for (int k = 0; k < 8; k++) begin
            check("grant_valid", seen_valid, 32'((k % (intv_set + 1)) == 0));
            if (seen_valid === 1'b1) check("grant_port", seen_port, port);
            next_cycle();
            check("cycle_len", gap, bus ? 22 : 44);
        end
    endtask

    // port 0 takes one cell and leaves, port 1 lost once and catches up when correction is on
    task automatic s_contend(input logic c, input cprs_poll_t m);
        b16 = 1'b1;
        corr = c;
        poll = m;
        cr = '0;
        cr[0] = 8'h01;
        cr[1] = 8'hFF;
        intv = '0;
        intv[1] = 8'h03;
        do_reset();
        next_cycle();
        check("first_port", {seen_valid, seen_port}, 32'h20);
        next_cycle();
        check("loser_port", {seen_valid, seen_port}, 32'h21);
        n = 0;
        do begin
            next_cycle();
            n++;
        end while (seen_valid !== 1'b1 && n < 8);
        check("reload_gap", n, c ? 3 : 4);
    endtask

    // port 0 loses to ports 1..nl in turn, then its next gap shows the clamped slip
    task automatic s_slip(input cprs_poll_t m, input int nl, input int exp_slip);
        b16 = 1'b1;
        corr = 1'b1;
        poll = m;
        cr = '0;
        intv = '0;
        for (int p = 0; p <= nl; p++) cr[p] = 8'h01;
        cr[0] = 8'hFF;
        do_reset();
        next_cycle();
        check("slip_first", {seen_valid, seen_port}, 32'h20);
        intv[0] = 8'h20;
        for (int p = 1; p <= nl; p++) begin
            next_cycle();
            check("slip_order", {seen_valid, seen_port}, 32'h20 | p);
        end
        next_cycle();
        check("slip_return", {seen_valid, seen_port}, 32'h20);
        n = 0;
        do begin
            next_cycle();
            n++;
        end while (seen_valid !== 1'b1 && n < 40);
        check("slip_gap", n, 33 - exp_slip);
    endtask

    // a low clock enable holds the pulse and stops the cycle timer
    task automatic s_freeze();
        b16 = 1'b1;
        corr = 1'b0;
        cr = '0;
        cr[2] = 8'hFF;
        intv = '0;
        do_reset();
        next_cycle();
        en = 1'b0;
        repeat (10) @(negedge clk);
        check("frozen_start", cyc, 1);
        check("frozen_grant", {gv, gp}, 32'h22);
        en = 1'b1;
        next_cycle();
        check("thawed_len", gap, 22);
        check("thawed_grant", {seen_valid, seen_port}, 32'h22);
    endtask

    // main sequence
    initial begin
        num_errors = 0;
        n_compared = 0;
        resetn = 1'b0;
        b16 = 1'b0;
        corr = 1'b0;
        load = 1'b0;
        en = 1'b1;
        poll = CPRS_POLL_12;
        intv = '0;
        cr = '0;
        s_rate(1'b0, 8'h02, 3);
        s_rate(1'b1, 8'h00, 5);
        s_rate(1'b0, 8'h01, 29);
        s_contend(1'b0, CPRS_POLL_12);
        for (int i = 0; i < 5; i++) s_contend(1'b1, cprs_poll_t'(5'h01 << i));
        s_slip(CPRS_POLL_12, 12, 11);
        s_slip(CPRS_POLL_15, 15, 14);
        s_slip(CPRS_POLL_MUX, 15, 15);
        s_slip(CPRS_POLL_2G, 15, 15);
        s_slip(CPRS_POLL_1G, 15, 15);
        s_freeze();
        end_sim();
    end
endmodule
